// ### pkg/pdbc_defs.vh
// Function
// - Decade variant counts BCD when chained
// - Decade splits into divide-by-two and divide-by-five
// - Two-by-five order gives symmetric MSB square
// - Binary variant divides by two to sixteen
// - Low load strobe copies data to outputs
// - Low reset clears all four outputs
// - Count only on falling clock edges
`ifndef PDBC_DEFS_VH
`define PDBC_DEFS_VH

// =====================================================================
// Widths
// =====================================================================
`define PDBC_CNT_W        4
`define PDBC_UP_W         3
`define PDBC_SYNC_W       9

// =====================================================================
// Field positions of the input synchroniser word
// =====================================================================
`define PDBC_SY_CLK1      0
`define PDBC_SY_CLK2      1
`define PDBC_SY_LOAD_N    2
`define PDBC_SY_CLEAR_N   3
`define PDBC_SY_DATA_LO   4
`define PDBC_SY_DATA_HI   7
`define PDBC_SY_DECADE    8

// =====================================================================
// Reset values and count limits
// =====================================================================
`define PDBC_CNT_RST      4'h0
`define PDBC_UP_RST       3'h0
`define PDBC_UP_ONE       3'h1
`define PDBC_QUIN_LAST    3'h4
`define PDBC_SYNC_RST     9'h00c

`endif

// ### hw/pdbc_sync.v
`include "pdbc_defs.vh"

// =====================================================================
// Two-stage synchroniser for pin inputs
// =====================================================================
module pdbc_sync (
    ref_clk,
    rst_n,
    clk_en,
    pin_in,
    pin_sync
);
    input  wire                    ref_clk;
    input  wire                    rst_n;
    input  wire                    clk_en;
    input  wire [`PDBC_SYNC_W-1:0] pin_in;
    output wire [`PDBC_SYNC_W-1:0] pin_sync;

    reg [`PDBC_SYNC_W-1:0] meta_q;
    reg [`PDBC_SYNC_W-1:0] sync_q;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= `PDBC_SYNC_RST;
            sync_q <= `PDBC_SYNC_RST;
        end else if (clk_en) begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;

endmodule // pdbc_sync

// ### hw/pdbc_top.v
`include "pdbc_defs.vh"

// =====================================================================
// Presettable decade / binary counter
// =====================================================================
module pdbc_top (
    ref_clk,
    reset_n,
    clk_en,
    decade_variant,
    two_by_five_order,
    count_clk1,
    count_clk2,
    load_n,
    clear_n,
    data_in,
    count_out
);
    input  wire                   ref_clk;
    input  wire                   reset_n;
    input  wire                   clk_en;
    input  wire                   decade_variant;
    input  wire                   two_by_five_order;
    input  wire                   count_clk1;
    input  wire                   count_clk2;
    input  wire                   load_n;
    input  wire                   clear_n;
    input  wire [`PDBC_CNT_W-1:0] data_in;
    output wire [`PDBC_CNT_W-1:0] count_out;

    // =================================================================
    // Reset release
    // =================================================================
    reg rst_meta_q;
    reg rst_sync_q;

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // =================================================================
    // Pin synchronisers
    // =================================================================
    wire [`PDBC_SYNC_W-1:0] pin_word;
    wire [`PDBC_SYNC_W-1:0] pin_sync;

    assign pin_word = {decade_variant, data_in, clear_n, load_n,
                       count_clk2, count_clk1};

    pdbc_sync u_sync (
        .ref_clk  (ref_clk),
        .rst_n    (rst_sync_q),
        .clk_en   (clk_en),
        .pin_in   (pin_word),
        .pin_sync (pin_sync)
    );

    wire                   clk1_s;
    wire                   clk2_s;
    wire                   load_n_s;
    wire                   clear_n_s;
    wire [`PDBC_CNT_W-1:0] data_s;
    wire                   decade_s;

    assign clk1_s    = pin_sync[`PDBC_SY_CLK1];
    assign clk2_s    = pin_sync[`PDBC_SY_CLK2];
    assign load_n_s  = pin_sync[`PDBC_SY_LOAD_N];
    assign clear_n_s = pin_sync[`PDBC_SY_CLEAR_N];
    assign data_s    = pin_sync[`PDBC_SY_DATA_HI:`PDBC_SY_DATA_LO];
    assign decade_s  = pin_sync[`PDBC_SY_DECADE];

    // Order strap is a plain level; keep it steady while counting
    reg order_meta_q;
    reg order_q;

    always @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            order_meta_q <= 1'b0;
            order_q      <= 1'b0;
        end else if (clk_en) begin
            order_meta_q <= two_by_five_order;
            order_q      <= order_meta_q;
        end
    end

    // =================================================================
    // Falling edge detection on the count clocks
    // =================================================================
    reg  clk1_prev_q;
    reg  clk2_prev_q;
    wire clk1_fall;
    wire clk2_fall;

    always @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            clk1_prev_q <= 1'b0;
            clk2_prev_q <= 1'b0;
        end else if (clk_en) begin
            clk1_prev_q <= clk1_s;
            clk2_prev_q <= clk2_s;
        end
    end

    assign clk1_fall = clk1_prev_q & ~clk1_s;
    assign clk2_fall = clk2_prev_q & ~clk2_s;

    // =================================================================
    // Upper section step
    // =================================================================
    // Decade wraps after four; out-of-range preset states fall back to zero
    function [`PDBC_UP_W-1:0] up_next;
        input [`PDBC_UP_W-1:0] cur;
        input                  quinary;
        begin
            if (quinary && (cur >= `PDBC_QUIN_LAST)) begin
                up_next = `PDBC_UP_RST;
            end else begin
                up_next = cur + `PDBC_UP_ONE;
            end
        end
    endfunction

    // =================================================================
    // Counter state
    // =================================================================
    reg                  half_q;
    reg                  half_d;
    reg [`PDBC_UP_W-1:0] up_q;
    reg [`PDBC_UP_W-1:0] up_d;
    wire                 biq_mode;
    wire                 quin_wrap;

    assign biq_mode  = decade_s & order_q;
    assign quin_wrap = (up_q >= `PDBC_QUIN_LAST);

    always @* begin
        half_d = half_q;
        up_d   = up_q;
        if (!clear_n_s) begin
            half_d = 1'b0;
            up_d   = `PDBC_UP_RST;
        end else if (!load_n_s) begin
            if (biq_mode) begin
                half_d = data_s[`PDBC_CNT_W-1];
                up_d   = data_s[`PDBC_UP_W-1:0];
            end else begin
                half_d = data_s[0];
                up_d   = data_s[`PDBC_CNT_W-1:1];
            end
        end else if (biq_mode) begin
            if (clk1_fall) begin
                up_d = up_next(up_q, 1'b1);
                if (quin_wrap) begin
                    half_d = ~half_q;
                end
            end
        end else begin
            if (clk1_fall) begin
                half_d = ~half_q;
            end
            if (clk2_fall) begin
                up_d = up_next(up_q, decade_s);
            end
        end
    end

    always @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            half_q <= 1'b0;
            up_q   <= `PDBC_UP_RST;
        end else if (clk_en) begin
            half_q <= half_d;
            up_q   <= up_d;
        end
    end

    // =================================================================
    // Output register
    // =================================================================
    // In two-by-five order of the decade variant the halving stage appears as the top bit
    reg [`PDBC_CNT_W-1:0] out_q;
    reg [`PDBC_CNT_W-1:0] out_d;

    always @* begin
        if (biq_mode) begin
            out_d = {half_d, up_d};
        end else begin
            out_d = {up_d, half_d};
        end
    end

    always @(posedge ref_clk or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            out_q <= `PDBC_CNT_RST;
        end else if (clk_en) begin
            out_q <= out_d;
        end
    end

    assign count_out = out_q;

endmodule // pdbc_top

// ### verification/pdbc_chk_assertions.sv
`include "pdbc_defs.vh"

// ==========
// Port checker
module pdbc_chk (
    ref_clk,
    reset_n,
    decade_variant,
    two_by_five_order,
    count_clk1,
    count_clk2,
    load_n,
    clear_n,
    data_in,
    count_out
);
    timeunit 1ns;
    timeprecision 100ps;
    input wire                   ref_clk;
    input wire                   reset_n;
    input wire                   decade_variant;
    input wire                   two_by_five_order;
    input wire                   count_clk1;
    input wire                   count_clk2;
    input wire                   load_n;
    input wire                   clear_n;
    input wire [`PDBC_CNT_W-1:0] data_in;
    input wire [`PDBC_CNT_W-1:0] count_out;
    wire run = load_n && clear_n;
    wire nrm = run && !two_by_five_order;
    wire qun = run && two_by_five_order;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    clear_wins_a: assert property (!clear_n [*5] |-> count_out == 4'h0)
        else $error("clear not applied");
    load_copy_a: assert property ((clear_n && !load_n && $stable(data_in)) [*8]
        |-> count_out == data_in) else $error("load not applied");
    count_idle_a: assert property ((run && !$fell(count_clk1) && !$fell(count_clk2))
        [*6] |=> $stable(count_out)) else $error("count moved without fall");
    upper_idle_a: assert property ((nrm && !$fell(count_clk2)) [*6]
        |=> $stable(count_out[3:1])) else $error("upper moved without fall");
    decade_range_a: assert property ((nrm && decade_variant) [*6]
        ##0 $changed(count_out[3:1]) |-> count_out[3:1] <= 3'h4)
        else $error("decade upper out of range");
    binary_step_a: assert property ((nrm && !decade_variant) [*6]
        ##0 $changed(count_out[3:1]) |-> count_out[3:1] == $past(count_out[3:1]) + 3'h1)
        else $error("binary upper skipped");
    quin_step_a: assert property (qun [*6] ##0 $changed(count_out[2:0])
        |-> count_out[2:0] == ($past(count_out[2:0]) == 3'h4 ? 3'h0
        : $past(count_out[2:0]) + 3'h1)) else $error("five step wrong");
    quin_msb_a: assert property (qun [*6] ##0 $changed(count_out[3])
        |-> count_out[2:0] == 3'h0 && $past(count_out[2:0]) == 3'h4)
        else $error("square bit moved early");
endmodule // pdbc_chk

bind pdbc_top pdbc_chk pdbc_chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .decade_variant(decade_variant), .two_by_five_order(two_by_five_order),
    .count_clk1(count_clk1), .count_clk2(count_clk2), .load_n(load_n),
    .clear_n(clear_n), .data_in(data_in), .count_out(count_out));

// ### verification/pdbc_far.sv
// ==========
// Clock source of the driving logic
module pdbc_far (
    ref_clk,
    link,
    q0,
    count_clk1,
    count_clk2
);
    timeunit 1ns;
    timeprecision 100ps;
    input  wire  ref_clk;
    input  wire  link;
    input  wire  q0;
    output logic count_clk1;
    output logic count_clk2;
    logic        c1_q = 1'b1;
    logic        c2_q = 1'b1;
    assign count_clk1 = c1_q;
    assign count_clk2 = link ? q0 : c2_q;
    task pulse(input logic sel);
        @(posedge ref_clk);
        if (sel)
            c2_q <= 1'b0;
        else
            c1_q <= 1'b0;
        repeat (4) @(posedge ref_clk);
        c1_q <= 1'b1;
        c2_q <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule // pdbc_far

// ### verification/pdbc_top_tb.sv
`include "pdbc_defs.vh"

// ==========
// Bench
module pdbc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic                   ref_clk;
    logic                   reset_n;
    logic                   clk_en;
    logic                   decade_variant;
    logic                   two_by_five_order;
    logic                   load_n;
    logic                   clear_n;
    logic                   link;
    logic [`PDBC_CNT_W-1:0] data_in;
    wire  [`PDBC_CNT_W-1:0] count_out;
    wire                    count_clk1;
    wire                    count_clk2;
    int                     error_cnt = 0;
    int                     total_checks = 0;
    pdbc_top pdbc_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
        .decade_variant(decade_variant), .two_by_five_order(two_by_five_order),
        .count_clk1(count_clk1), .count_clk2(count_clk2), .load_n(load_n),
        .clear_n(clear_n), .data_in(data_in), .count_out(count_out));
    pdbc_far pdbc_far_i (.ref_clk(ref_clk), .link(link), .q0(count_out[0]),
        .count_clk1(count_clk1), .count_clk2(count_clk2));
    task end_sim;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task ld(input logic dec, input logic tbf, input logic [3:0] d);
        @(posedge ref_clk);
        load_n <= 1'b0;
        decade_variant <= dec;
        two_by_five_order <= tbf;
        data_in <= d;
        repeat (8) @(posedge ref_clk);
        chk(count_out, d);
        load_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
    endtask
    task step(input logic sel, input logic [3:0] e);
        pdbc_far_i.pulse(sel);
        repeat (2) @(posedge ref_clk);
        chk(count_out, e);
    endtask
    task t_clear;
        ld(1'b1, 1'b0, 4'hf);
        clear_n <= 1'b0;
        load_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(count_out, 4'h0);
        clear_n <= 1'b1;
        load_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk(count_out, 4'h0);
    endtask
    task t_split;
        link <= 1'b0;
        ld(1'b1, 1'b0, 4'h0);
        step(1'b0, 4'h1);
        step(1'b0, 4'h0);
        for (int i = 1; i <= 5; i++)
            step(1'b1, 4'((i % 5) * 2));
    endtask
    task t_bcd;
        link <= 1'b1;
        ld(1'b1, 1'b0, 4'h0);
        for (int i = 1; i <= 10; i++)
            step(1'b0, 4'(i % 10));
    endtask
    task t_bin;
        ld(1'b0, 1'b0, 4'h0);
        for (int i = 1; i <= 16; i++)
            step(1'b0, 4'(i % 16));
    endtask
    task t_quin;
        link <= 1'b0;
        ld(1'b1, 1'b1, 4'h0);
        for (int i = 1; i <= 10; i++)
            step(1'b0, 4'((i / 5) % 2 * 8 + i % 5));
    endtask
    // Out-of-range decade preset, then a clock fall hidden by a frozen enable
    task t_freeze;
        link <= 1'b0;
        ld(1'b1, 1'b0, 4'he);
        step(1'b1, 4'h0);
        clk_en <= 1'b0;
        pdbc_far_i.pulse(1'b0);
        clk_en <= 1'b1;
        repeat (4) @(posedge ref_clk);
        chk(count_out, 4'h0);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        end_sim();
    end
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        load_n = 1'b1;
        clear_n = 1'b1;
        link = 1'b0;
        data_in = 4'h0;
        decade_variant = 1'b1;
        two_by_five_order = 1'b0;
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_clear();
        t_split();
        t_bcd();
        t_bin();
        t_quin();
        t_freeze();
        end_sim();
    end
endmodule // pdbc_top_tb
